// [design/can_tx_event_fifo_ctrl.sv]
// Notes on behaviour
// - depth field bits 28..24 give queue depth as field plus one, 1 to 32.
// - writing one to bit 10 clears the queue; hardware drops the bit once mode no longer equals configuration.
// - writing one to bit 8 releases the oldest entry, tail moves by one.
// - bit 5 set makes stored entries carry a time stamp, clear omits it.
// - control bit 3 enables the overflow interrupt request.
// - control bit 2 enables the full interrupt request.
// - control bit 1 enables the half-full interrupt request.
// - control bit 0 enables the not-empty interrupt request.
// - depth and stamp enable change only while mode equals configuration.
// - status bit 3 is set by overflow and stays until software clears it.
// - status bit 2 reads one exactly when all configured entries are occupied.
// - status bit 1 reads one when occupancy is at least half the depth.
// - status bit 0 reads one while at least one entry is held.
// - full, half and not-empty bits are read-only and follow live occupancy.
// - status bits 31..4 and unused control bits read as zero.
`timescale 1ns/1ps
`include "tx_event_consts.svh"

module can_tx_event_fifo_ctrl #(
  parameter int ADDR_W = 8
) (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic [ADDR_W-1:0]     addr,
  input  wire logic [31:0]           wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output      logic [31:0]           rdata,
  input  wire tx_event_pkg::mode_t   operating_mode_field,
  input  wire logic                  tx_done,
  output      logic                  store_valid,
  output      logic [4:0]            store_slot,
  output      logic                  store_stamp,
  output      logic [4:0]            tail_slot,
  output      logic                  irq
);

  // refuse address widths that cannot hold both register offsets
  if (ADDR_W < 3 || ADDR_W > 8) begin : addr_w_check
    $error("ADDR_W must lie between 3 and 8");
  end

  // ==========================================================
  // state
  tx_event_pkg::depth_code_t depth_field_reg;
  logic                      stamp_enable_reg;
  logic [3:0]                irq_enable_reg;
  logic                      fifo_clear_bit_reg;
  logic                      overflow_flag_reg;
  tx_event_pkg::level_t      count_reg;
  logic [4:0]                head_reg;
  logic [4:0]                tail_reg;
  logic [31:0]               rdata_reg;
  logic                      irq_reg;
  logic                      store_valid_reg;
  logic [4:0]                store_slot_reg;
  logic                      store_stamp_reg;

  // ==========================================================
  // decode
  logic                      ctrl_sel;
  logic                      stat_sel;
  logic                      ctrl_wr;
  logic                      stat_wr;
  logic                      cfg_mode;
  tx_event_pkg::level_t      depth;
  logic                      full_flag;
  logic                      half_flag;
  logic                      nonempty_flag;
  logic                      do_push;
  logic                      do_pop;
  logic                      overflow_evt;
  logic [3:0]                flags;

  assign ctrl_sel = (addr == ADDR_W'(`TXQ_CTRL_OFS));
  assign stat_sel = (addr == ADDR_W'(`TXQ_STAT_OFS));
  assign ctrl_wr  = wr && ctrl_sel;
  assign stat_wr  = wr && stat_sel;
  assign cfg_mode = (operating_mode_field == `TXQ_MODE_CONFIG);

  assign depth = {1'b0, depth_field_reg} + 6'h01;

  // full when every entry is held
  assign full_flag     = (count_reg == depth);
  // half when twice occupancy reaches depth
  assign half_flag     = ({count_reg, 1'b0} >= {1'b0, depth});
  assign nonempty_flag = (count_reg != 6'h00);

  // a clear in progress holds the queue empty, so pushes and pops are lost
  assign overflow_evt = tx_done && full_flag && !fifo_clear_bit_reg;
  assign do_push      = tx_done && !full_flag && !fifo_clear_bit_reg;
  // tail advance on a written one, only when an entry exists
  assign do_pop       = ctrl_wr && wdata[`TXQ_ADVANCE_BIT] && nonempty_flag && !fifo_clear_bit_reg;

  assign flags = {overflow_flag_reg, full_flag, half_flag, nonempty_flag};

  // ==========================================================
  // configuration fields
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      depth_field_reg  <= `TXQ_DEPTH_RST;
      stamp_enable_reg <= 1'b0;
    end else if (ctrl_wr && cfg_mode) begin
      depth_field_reg  <= wdata[`TXQ_DEPTH_HI:`TXQ_DEPTH_LO];
      stamp_enable_reg <= wdata[`TXQ_STAMP_BIT];
    end
  end

  // interrupt enables are writable in any mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_enable_reg <= `TXQ_ENABLES_RST;
    end else if (ctrl_wr) begin
      irq_enable_reg <= wdata[`TXQ_OVF_BIT:`TXQ_NEMPTY_BIT];
    end
  end

  // ==========================================================
  // queue clear: held in configuration mode, dropped once outside it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fifo_clear_bit_reg <= `TXQ_CLEAR_RST;
    // software sets, hardware clears once outside configuration mode, as the pointers are reset
    end else if (ctrl_wr && wdata[`TXQ_CLEAR_BIT]) begin
      fifo_clear_bit_reg <= 1'b1;
    end else if (fifo_clear_bit_reg && !cfg_mode) begin
      fifo_clear_bit_reg <= 1'b0;
    end
  end

  // ==========================================================
  // occupancy and pointers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= 6'h00;
      head_reg  <= 5'h00;
      tail_reg  <= 5'h00;
    end else if (fifo_clear_bit_reg) begin
      count_reg <= 6'h00;
      head_reg  <= 5'h00;
      tail_reg  <= 5'h00;
    end else begin
      if (do_push) begin
        head_reg <= (head_reg == depth_field_reg) ? 5'h00 : head_reg + 5'h01;
      end
      if (do_pop) begin
        tail_reg <= (tail_reg == depth_field_reg) ? 5'h00 : tail_reg + 5'h01;
      end
      // occupancy moves only with pushes and pops
      case ({do_push, do_pop})
        2'b10:   count_reg <= count_reg + 6'h01;
        2'b01:   count_reg <= count_reg - 6'h01;
        default: count_reg <= count_reg;
      endcase
    end
  end

  // ==========================================================
  // overflow flag: set wins over a same-cycle clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      overflow_flag_reg <= 1'b0;
    end else if (overflow_evt) begin
      overflow_flag_reg <= 1'b1;
    end else if (stat_wr && wdata[`TXQ_OVF_BIT]) begin
      overflow_flag_reg <= 1'b0;
    end
  end

  // ==========================================================
  // storage strobe toward the entry memory
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      store_valid_reg <= 1'b0;
      store_slot_reg  <= 5'h00;
      store_stamp_reg <= 1'b0;
    end else begin
      store_valid_reg <= do_push;
      if (do_push) begin
        store_slot_reg  <= head_reg;
        // entry carries a stamp when enabled
        store_stamp_reg <= stamp_enable_reg;
      end
    end
  end

  // ==========================================================
  // read port
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= 32'h00000000;
      if (rd && ctrl_sel) begin
        rdata_reg[`TXQ_DEPTH_HI:`TXQ_DEPTH_LO] <= depth_field_reg;
        rdata_reg[`TXQ_CLEAR_BIT]             <= fifo_clear_bit_reg;
        rdata_reg[`TXQ_STAMP_BIT]             <= stamp_enable_reg;
        rdata_reg[`TXQ_OVF_BIT:`TXQ_NEMPTY_BIT] <= irq_enable_reg;
      end else if (rd && stat_sel) begin
        rdata_reg[`TXQ_OVF_BIT:`TXQ_NEMPTY_BIT] <= flags;
      end
    end
  end

  // ==========================================================
  // interrupt
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flags & irq_enable_reg);
    end
  end

  assign rdata       = rdata_reg;
  assign irq         = irq_reg;
  assign store_valid = store_valid_reg;
  assign store_slot  = store_slot_reg;
  assign store_stamp = store_stamp_reg;
  assign tail_slot   = tail_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_depth_bound: assert property (count_reg <= depth)
    else $error("occupancy beyond configured depth");

  a_clear_done: assert property (
    fifo_clear_bit_reg && !cfg_mode && !ctrl_wr |=> !fifo_clear_bit_reg && count_reg == 6'h00)
    else $error("queue clear did not finish");

  a_tail_step: assert property (do_pop && !do_push |=> count_reg == $past(count_reg) - 6'h01)
    else $error("tail advance did not release one entry");

  a_stamp_copy: assert property (do_push |=> store_valid && store_stamp == $past(stamp_enable_reg))
    else $error("stamp marker mismatch");

  a_cfg_lock: assert property (!cfg_mode |=> $stable(depth_field_reg) && $stable(stamp_enable_reg))
    else $error("configuration changed outside configuration mode");

  a_ovf_sticky: assert property (overflow_evt |=> overflow_flag_reg)
    else $error("overflow flag not set");

  a_ovf_hold: assert property (overflow_flag_reg && !(stat_wr && wdata[`TXQ_OVF_BIT]) |=> overflow_flag_reg)
    else $error("overflow flag dropped without clear");

  a_full_read: assert property (rd && stat_sel |=> rdata[`TXQ_FULL_BIT] == $past(count_reg == depth))
    else $error("full status wrong");

  a_half_read: assert property (rd && stat_sel |=> rdata[`TXQ_HALF_BIT] == $past(2 * count_reg >= depth))
    else $error("half status wrong");

  a_nempty_read: assert property (
    rd && stat_sel |=> rdata[`TXQ_NEMPTY_BIT] == $past(count_reg != 6'h00) && (rdata & ~`TXQ_STAT_MASK) == 32'h0)
    else $error("not-empty status or upper bits wrong");

  a_irq_level: assert property (##1 irq == $past(|(flags & irq_enable_reg)))
    else $error("interrupt does not follow gated flags");

  // ==========================================================
  // assertions: clear, pointers, occupancy, configuration write and entry strobe

  a_clear_set: assert property (ctrl_wr && wdata[`TXQ_CLEAR_BIT] |=> fifo_clear_bit_reg)
    else $error("queue clear request not taken");

  a_clear_hold: assert property (fifo_clear_bit_reg && cfg_mode |=> fifo_clear_bit_reg)
    else $error("queue clear dropped in configuration mode");

  a_clear_empty: assert property (fifo_clear_bit_reg |=> count_reg == 6'h00 && tail_reg == 5'h00)
    else $error("queue not emptied by clear");

  a_clear_read: assert property (rd && ctrl_sel |=> rdata[`TXQ_CLEAR_BIT] == $past(fifo_clear_bit_reg))
    else $error("clear bit read back wrong");

  a_depth_read: assert property (
    rd && ctrl_sel |=> rdata[`TXQ_DEPTH_HI:`TXQ_DEPTH_LO] == $past(depth_field_reg))
    else $error("depth field read back wrong");

  a_tail_wrap: assert property (do_pop && tail_reg == depth_field_reg |=> tail_reg == 5'h00)
    else $error("tail did not wrap at configured depth");

  a_head_wrap: assert property (do_push && head_reg == depth_field_reg |=> head_reg == 5'h00)
    else $error("head did not wrap at configured depth");

  a_tail_hold: assert property (!do_pop && !fifo_clear_bit_reg |=> $stable(tail_reg))
    else $error("tail moved without an advance");

  a_push_step: assert property (do_push && !do_pop |=> count_reg == $past(count_reg) + 6'h01)
    else $error("push did not add one entry");

  a_count_hold: assert property (do_push == do_pop && !fifo_clear_bit_reg |=> $stable(count_reg))
    else $error("occupancy changed without push or pop");

  a_store_idle: assert property (!do_push |=> !store_valid && $stable(store_slot) && $stable(store_stamp))
    else $error("entry strobe or marker changed without a push");

  a_cfg_write: assert property (
    ctrl_wr && cfg_mode |=> depth_field_reg == $past(wdata[`TXQ_DEPTH_HI:`TXQ_DEPTH_LO])
    && stamp_enable_reg == $past(wdata[`TXQ_STAMP_BIT]))
    else $error("configuration write in configuration mode lost");

  // ==========================================================
  // assertions: overflow and read port

  a_ovf_clear: assert property (stat_wr && wdata[`TXQ_OVF_BIT] && !overflow_evt |=> !overflow_flag_reg)
    else $error("overflow flag not cleared by a written one");

  a_ovf_cause: assert property (!overflow_flag_reg && !overflow_evt |=> !overflow_flag_reg)
    else $error("overflow flag set without an overflow");

  a_ctrl_zero: assert property (rd && ctrl_sel |=> (rdata & ~`TXQ_CTRL_MASK) == 32'h0)
    else $error("unused control bits read nonzero");

  a_rdata_idle: assert property (!rd |=> rdata == 32'h00000000)
    else $error("read data nonzero without a read");

  // ==========================================================
  // assertions: interrupt gating

  a_ovf_irq: assert property (overflow_flag_reg && irq_enable_reg[`TXQ_OVF_BIT] |=> irq)
    else $error("enabled overflow raised no interrupt");

  a_full_irq: assert property (full_flag && irq_enable_reg[`TXQ_FULL_BIT] |=> irq)
    else $error("enabled full raised no interrupt");

  a_half_irq: assert property (half_flag && irq_enable_reg[`TXQ_HALF_BIT] |=> irq)
    else $error("enabled half-full raised no interrupt");

  a_nempty_irq: assert property (nonempty_flag && irq_enable_reg[`TXQ_NEMPTY_BIT] |=> irq)
    else $error("enabled not-empty raised no interrupt");

  a_irq_masked: assert property (irq_enable_reg == 4'h0 |=> !irq)
    else $error("interrupt raised with every source masked");

endmodule // can_tx_event_fifo_ctrl

// [design/tx_event_consts.svh]
`ifndef TX_EVENT_CONSTS_SVH
`define TX_EVENT_CONSTS_SVH

// register byte offsets
`define TXQ_CTRL_OFS        8'h00
`define TXQ_STAT_OFS        8'h04

// control register fields
`define TXQ_DEPTH_HI        28
`define TXQ_DEPTH_LO        24
`define TXQ_CLEAR_BIT       10
`define TXQ_ADVANCE_BIT     8
`define TXQ_STAMP_BIT       5
`define TXQ_OVF_BIT         3
`define TXQ_FULL_BIT        2
`define TXQ_HALF_BIT        1
`define TXQ_NEMPTY_BIT      0

// positions that read back; everything else reads zero
`define TXQ_CTRL_MASK       32'h1F00_042F
`define TXQ_STAT_MASK       32'h0000_000F

// reset values
`define TXQ_DEPTH_RST       5'h00
`define TXQ_ENABLES_RST     4'h0
`define TXQ_CLEAR_RST       1'b1

// operating mode encoding that opens the configuration fields
`define TXQ_MODE_CONFIG     3'h4

`endif

// [design/tx_event_pkg.sv]
package tx_event_pkg;
  typedef logic [2:0]  mode_t;
  typedef logic [4:0]  depth_code_t;
  typedef logic [5:0]  level_t;
  typedef logic [31:0] word_t;
endpackage

// [testbench/testbench.sv]
`timescale 1ns/1ps

module testbench;
  // ==========================================================
  // signals
  logic                clk;
  logic                nrst;
  logic [7:0]          addr;
  logic [31:0]         wdata;
  logic                wr;
  logic                rd;
  logic [31:0]         rdata;
  tx_event_pkg::mode_t mode;
  logic                tx_done;
  logic                store_valid;
  logic [4:0]          store_slot;
  logic                store_stamp;
  logic [4:0]          tail_slot;
  logic                irq;
  int                  error_cnt;
  int                  checked;
  int                  dep;
  int                  cnt;
  int                  head;
  int                  tail;
  logic                stamp;
  logic                ovf;
  logic [3:0]          en;
  logic [31:0]         v;

  can_tx_event_fifo_ctrl #(.ADDR_W(8)) uut (
    .clk                  (clk),
    .nrst                 (nrst),
    .addr                 (addr),
    .wdata                (wdata),
    .wr                   (wr),
    .rd                   (rd),
    .rdata                (rdata),
    .operating_mode_field (mode),
    .tx_done              (tx_done),
    .store_valid          (store_valid),
    .store_slot           (store_slot),
    .store_stamp          (store_stamp),
    .tail_slot            (tail_slot),
    .irq                  (irq)
  );

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
    end
    @(posedge clk) wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) begin
      addr <= a;
      rd   <= 1'b1;
    end
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic logic [31:0] exp_stat();
    return {28'h0, ovf, 1'(cnt == dep), 1'(2 * cnt >= dep), 1'(cnt > 0)};
  endfunction

  function automatic logic [31:0] ctrl_word();
    logic [31:0] c;
    c = 32'h0;
    c[28:24] = 5'(dep - 1);
    c[5] = stamp;
    c[3:0] = en;
    return c;
  endfunction

  task automatic check_flags;
    rreg(8'h04, v);
    chk(v, exp_stat());
    chk(irq, |(exp_stat() & {28'h0, en}));
  endtask

  // ==========================================================
  // scenarios
  task automatic cfg(input int d);
    logic [31:0] w;
    int          m;
    m = $urandom % 8;
    @(posedge clk) mode <= 3'h4;
    stamp = 1'($urandom);
    en = 4'($urandom);
    w = ($urandom & 32'hE0FF_FAD0) | {3'h0, 5'(d), 24'h0} | 32'h0000_0400 | {26'h0, stamp, 1'b0, en};
    wreg(8'h00, w);
    rreg(8'h00, v);
    chk(v, w & 32'h1F00_042F);
    dep = d + 1;
    cnt = 0;
    head = 0;
    tail = 0;
    @(posedge clk) mode <= (m == 4) ? 3'h0 : 3'(m);
    en = 4'($urandom);
    wreg(8'h00, {3'h0, ~5'(d), 18'h0, ~stamp, 1'b0, en});
    rreg(8'h00, v);
    chk(v, ctrl_word());
  endtask

  task automatic push;
    logic ok;
    ok = (cnt < dep);
    @(posedge clk) tx_done <= 1'b1;
    @(posedge clk) tx_done <= 1'b0;
    #1 chk(store_valid, ok);
    if (ok) begin
      chk(store_slot, head);
      chk(store_stamp, stamp);
      head = (head + 1) % dep;
      cnt++;
    end else begin
      ovf = 1'b1;
    end
    check_flags();
  endtask

  task automatic adv;
    wreg(8'h00, ctrl_word() | 32'h0000_0100);
    if (cnt > 0) begin
      tail = (tail + 1) % dep;
      cnt--;
    end
    #1 chk(tail_slot, tail);
    check_flags();
  endtask

  // fill past full, drain past empty, then clear the sticky overflow
  task automatic round(input int d);
    cfg(d);
    for (int i = 0; i <= dep; i++) push();
    for (int i = 0; i <= dep; i++) adv();
    wreg(8'h04, 32'hFFFF_FFFF);
    ovf = 1'b0;
    check_flags();
  endtask

  initial begin
    nrst      = 1'b0;
    addr      = 8'h00;
    wdata     = 32'h0;
    wr        = 1'b0;
    rd        = 1'b0;
    mode      = 3'h4;
    tx_done   = 1'b0;
    error_cnt = 0;
    checked   = 0;
    ovf       = 1'b0;
    void'($urandom(91));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rreg(8'h00, v);
    chk(v, 32'h0000_0400);
    rreg(8'h04, v);
    chk(v, 32'h0);
    chk(irq, 1'b0);
    wreg(8'h08, 32'hFFFF_FFFF);
    rreg(8'h08, v);
    chk(v, 32'h0);
    round(0);
    round(31);
    round(1);
    // reset in mid-run with entries held: all state returns to its reset value
    cfg(7);
    repeat (3) push();
    @(posedge clk) begin
      nrst <= 1'b0;
      mode <= 3'h4;
    end
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    dep = 1;
    cnt = 0;
    ovf = 1'b0;
    en  = 4'h0;
    #1 chk(tail_slot, 5'h00);
    chk(store_valid, 1'b0);
    chk(store_stamp, 1'b0);
    rreg(8'h00, v);
    chk(v, 32'h0000_0400);
    check_flags();
    repeat (3) round($urandom % 32);
    finish_test();
  end

  // the full run needs well under 5000 cycles
  initial begin
    #(25 * 50000);
    error_cnt++;
    finish_test();
  end
endmodule // testbench
